// >>> inc/dsam_pkg.sv
// Shared constants for the dual sensor alarm monitor: register map,
// field positions, reset values and source encodings.
// Assumes the sensor front end delivers 14-bit raw samples for all sources.
package dsam_pkg;
  localparam int LIM_W = 14;          // Limit and sample width
  localparam int SMP_W = 8;           // Rate sample count width
  localparam int SRC_NUM = 7;         // Number of monitored variables
  localparam int FRAME_BITS = 16;     // Serial frame length
  localparam int FRAME_WR_BIT = 15;   // Write flag in a frame
  localparam int FRAME_ADDR_LSB = 8;  // Address field low bit
  localparam int ADDR_W = 7;          // Serial address width
  // Register byte addresses
  localparam logic [6:0] ADDR_LIM1 = 7'h20;
  localparam logic [6:0] ADDR_LIM2 = 7'h22;
  localparam logic [6:0] ADDR_SMP1 = 7'h24;
  localparam logic [6:0] ADDR_SMP2 = 7'h26;
  localparam logic [6:0] ADDR_CTRL = 7'h28;
  localparam logic [6:0] ADDR_STATUS = 7'h2A;
  // Reset values and writable bit masks
  localparam logic [15:0] NV_RESET = 16'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] MASK_LIM = 16'hBFFF;
  localparam logic [15:0] MASK_SMP = 16'h00FF;
  localparam logic [15:0] MASK_CTRL = 16'hFF07;
  // Field positions
  localparam int LIM_ABOVE_BIT = 15;
  localparam int CTRL_RATE2 = 15;
  localparam int CTRL_SRC2_LSB = 12;
  localparam int CTRL_RATE1 = 11;
  localparam int CTRL_SRC1_LSB = 8;
  localparam int CTRL_OUT_EN = 2;
  localparam int CTRL_OUT_POL = 1;
  localparam int CTRL_OUT_LINE = 0;
  // Which sources are twos complement, bit n for source code n+1
  localparam logic [6:0] SRC_SIGNED = 7'h66;
  // Source selector codes
  typedef enum logic [2:0] {
    SRC_OFF, SRC_SUPPLY, SRC_XACC, SRC_YACC,
    SRC_AUX, SRC_TEMP, SRC_XTILT, SRC_YTILT
  } dsam_src_t;
endpackage : dsam_pkg

// >>> logic/dsam_channel.sv
// One alarm comparator: threshold or averaged rate-of-change check.
// Assumes i_value is already the selected raw sample, i_sample_valid
// a one-cycle pulse per update, all on i_clk_sys.
`timescale 1ns/1ns
module dsam_channel
  import dsam_pkg::*;
#(
  parameter int DATA_W = LIM_W  // Sample and limit width
) (
  input wire logic i_clk_sys,              // System clock
  input wire logic i_rst,                  // Sync reset, high
  input wire logic i_sample_valid,         // New sample pulse
  input wire logic i_enable,               // Source code not off
  input wire logic i_rate_mode,            // 1 rate, 0 threshold
  input wire logic i_signed,               // Sample is twos complement
  input wire logic [DATA_W-1:0] i_value,   // Raw sample
  input wire logic [15:0] i_limit,         // Limit register
  input wire logic [SMP_W-1:0] i_samples,  // Rate sample count
  output logic o_alarm                     // Alarm state
);
  localparam int WW = DATA_W + 11;  // Room for delta and limit times count
  generate
    if (DATA_W < 2 || DATA_W > 14) begin : g_bad_width
      $error("dsam_channel: DATA_W out of range");
    end
  endgenerate
  typedef struct packed {
    logic [DATA_W:0] ref_v;  // Sample that opened the rate window
    logic [SMP_W-1:0] cnt;   // Samples since window start
    logic primed;            // Window has a start sample
    logic alarm;             // Present alarm state
  } dsam_ch_t;
  dsam_ch_t st_q, st_d;
  // Extend to a common signed width per the source number format
  function automatic logic signed [WW-1:0] widen(input logic [DATA_W-1:0] v, input logic sgn);
    widen = {{(WW - DATA_W){sgn & v[DATA_W-1]}}, v};
  endfunction : widen
  // Direction test shared by both modes
  function automatic logic hit(input logic signed [WW-1:0] a, input logic signed [WW-1:0] b,
                               input logic above);
    hit = above ? (a > b) : (a < b);
  endfunction : hit
  logic signed [WW-1:0] cur, lim, delta, scaled;
  logic [SMP_W:0] n_eff;
  logic above, thr_hit;
  // Next state: evaluated on every sample pulse
  always_comb begin
    st_d = st_q;
    cur = widen(i_value, i_signed);
    lim = widen(i_limit[DATA_W-1:0], i_signed);
    above = i_limit[LIM_ABOVE_BIT];
    n_eff = (i_samples == '0) ? (SMP_W+1)'(1) : {1'b0, i_samples};
    delta = cur - widen(st_q.ref_v[DATA_W-1:0], i_signed);
    // Averaged change over n is compared as delta against limit times n, avoiding a divider
    scaled = WW'(lim * $signed({1'b0, n_eff}));
    thr_hit = hit(cur, lim, above);
    if (!i_enable) begin
      // Disabled channel never alarms and loses its window
      st_d.alarm = 1'b0;
      st_d.primed = 1'b0;
      st_d.cnt = '0;
    end else if (i_sample_valid) begin
      if (!i_rate_mode) begin
        st_d.alarm = thr_hit;
        st_d.primed = 1'b0;
      end else if (!st_q.primed) begin
        // First sample only opens the window
        st_d.ref_v = cur[DATA_W:0];
        st_d.cnt = '0;
        st_d.primed = 1'b1;
      end else if ({1'b0, st_q.cnt} + (SMP_W+1)'(1) >= n_eff) begin
        st_d.alarm = hit(delta, scaled, above);
        st_d.ref_v = cur[DATA_W:0];
        st_d.cnt = '0;
      end else begin
        st_d.cnt = st_q.cnt + SMP_W'(1);
      end
    end
  end
  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_alarm = st_q.alarm;
  chan_off_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_enable |=> !o_alarm) else $error("disabled channel alarms");
  thr_compare_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_enable && i_sample_valid && !i_rate_mode |=> o_alarm == $past(thr_hit))
    else $error("threshold compare wrong");
endmodule : dsam_channel

// >>> logic/dsam_pin_mux.sv
// Priority selection of who drives each auxiliary line.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module dsam_pin_mux
  import dsam_pkg::*;
(
  input wire logic [1:0] i_misc_claim,  // Misc control owns line
  input wire logic [1:0] i_misc_level,  // Misc drive level
  input wire logic i_alarm_en,          // Indicator enabled
  input wire logic i_alarm_line,        // Indicator line index
  input wire logic i_alarm_level,       // Indicator level
  input wire logic [1:0] i_gpio_oe,     // General I/O drives line
  input wire logic [1:0] i_gpio_level,  // General I/O level
  output logic [1:0] o_out,             // Line level
  output logic [1:0] o_oe               // Line enable
);
  // Per line: misc first, then alarm, then general I/O
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (i_misc_claim[k]) begin
        o_out[k] = i_misc_level[k];
        o_oe[k] = 1'b1;
      end else if (i_alarm_en && (i_alarm_line == k[0])) begin
        o_out[k] = i_alarm_level;
        o_oe[k] = 1'b1;
      end else begin
        o_out[k] = i_gpio_level[k];
        o_oe[k] = i_gpio_oe[k];
      end
    end
  end
endmodule : dsam_pin_mux

// >>> logic/dsam_top.sv
// Dual sensor alarm monitor: serial register slave, two alarm
// channels and the shared hardware alarm indicator.
// Assumes raw samples and their update pulse come from the sampling
// system on i_clk_sys; serial pins are asynchronous and slow.
`timescale 1ns/1ns
module dsam_top
  import dsam_pkg::*;
(
  input wire logic i_clk_sys,                           // System clock
  input wire logic i_rst,                               // Sync reset, high
  input wire logic i_por,                               // Power-on clear, high
  input wire logic i_spi_sclk,                          // Serial clock pin
  input wire logic i_spi_cs_n,                          // Serial select, low
  input wire logic i_spi_din,                           // Serial data in
  output logic o_spi_dout,                              // Serial data out
  output logic o_spi_dout_oe,                           // Data out enable
  input wire logic i_sample_valid,                      // Samples updated
  input wire logic [SRC_NUM-1:0][LIM_W-1:0] i_raw_sample, // Unfiltered samples
  input wire logic [1:0] i_misc_claim,                  // Misc owns line
  input wire logic [1:0] i_misc_level,                  // Misc level
  input wire logic [1:0] i_gpio_oe,                     // General I/O enable
  input wire logic [1:0] i_gpio_level,                  // General I/O level
  output logic [1:0] o_aux_out,                         // Aux line level
  output logic [1:0] o_aux_oe                           // Aux line enable
);

  // All state of the block
  typedef struct packed {
    logic [2:0] sclk_s;             // Clock synchroniser and edge stage
    logic [2:0] cs_s;               // Select synchroniser and edge stage
    logic [1:0] din_s;              // Data synchroniser
    logic [15:0] rx;                // Incoming frame
    logic [15:0] tx;                // Outgoing frame
    logic [4:0] bits;               // Bits received in frame
    logic [ADDR_W-1:0] rd_addr;     // Address for next read frame
    logic [3:0][15:0] nv;           // Limits then sample counts
    logic [15:0] ctrl;              // Shared alarm control
    logic [1:0] aux_out;            // Registered line levels
    logic [1:0] aux_oe;             // Registered line enables
    logic miso;                     // Serial out bit
    logic miso_oe;                  // Serial out enable
  } dsam_top_t;

  dsam_top_t st_q, st_d;

  // Channel outputs and indicator terms
  logic [1:0] alarm;                // Per channel alarm
  logic any_alarm;                  // Either channel
  logic ind_level;                  // Indicator after polarity
  logic [1:0] mux_out, mux_oe;      // Pin priority result
  dsam_src_t src1, src2;            // Selected sources
  logic [LIM_W-1:0] val1, val2;     // Selected raw samples
  logic sgn1, sgn2;                 // Number format of each

  // Serial edge and frame terms
  logic sclk_rise, sclk_fall;
  logic cs_act, cs_fall;
  logic [15:0] rx_full;
  logic frame_done;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;

  // Index of a source in the raw sample vector; code 000 is never used
  function automatic logic [2:0] src_idx(input dsam_src_t s);
    src_idx = (s == SRC_OFF) ? 3'h0 : 3'(s - 3'h1);
  endfunction : src_idx

  // Writable-bit mask for a register byte address; zero for the status register and unmapped addresses
  function automatic logic [15:0] wr_mask(input logic [ADDR_W-1:0] a);
    case ({a[ADDR_W-1:1], 1'b0})
      ADDR_LIM1, ADDR_LIM2: wr_mask = MASK_LIM;
      ADDR_SMP1, ADDR_SMP2: wr_mask = MASK_SMP;
      ADDR_CTRL: wr_mask = MASK_CTRL;
      default: wr_mask = 16'h0000;
    endcase
  endfunction : wr_mask

  // Register read view; unmapped addresses read as zero
  function automatic logic [15:0] reg_read(input logic [ADDR_W-1:0] a, input dsam_top_t s,
                                           input logic [1:0] alm);
    case ({a[ADDR_W-1:1], 1'b0})
      ADDR_LIM1: reg_read = s.nv[0];
      ADDR_LIM2: reg_read = s.nv[1];
      ADDR_SMP1: reg_read = s.nv[2];
      ADDR_SMP2: reg_read = s.nv[3];
      ADDR_CTRL: reg_read = s.ctrl;
      ADDR_STATUS: reg_read = {14'h0000, alm};
      default: reg_read = 16'h0000;
    endcase
  endfunction : reg_read

  // Source selection per channel from the shared control word
  always_comb begin
    src1 = dsam_src_t'(st_q.ctrl[CTRL_SRC1_LSB +: 3]);
    src2 = dsam_src_t'(st_q.ctrl[CTRL_SRC2_LSB +: 3]);
    val1 = i_raw_sample[src_idx(src1)];
    val2 = i_raw_sample[src_idx(src2)];
    sgn1 = SRC_SIGNED[src_idx(src1)];
    sgn2 = SRC_SIGNED[src_idx(src2)];
  end

  // Channel one: its own limit and count registers
  dsam_channel #(
    .DATA_W(LIM_W)
  ) u_chan_one (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst || i_por),                // Either reset clears the window
    .i_sample_valid(i_sample_valid),
    .i_enable(src1 != SRC_OFF),
    .i_rate_mode(st_q.ctrl[CTRL_RATE1]),
    .i_signed(sgn1),
    .i_value(val1),
    .i_limit(st_q.nv[0]),
    .i_samples(st_q.nv[2][SMP_W-1:0]),
    .o_alarm(alarm[0])
  );

  // Channel two compares against its own limit, in both modes
  dsam_channel #(
    .DATA_W(LIM_W)
  ) u_chan_two (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst || i_por),                // Either reset clears the window
    .i_sample_valid(i_sample_valid),
    .i_enable(src2 != SRC_OFF),
    .i_rate_mode(st_q.ctrl[CTRL_RATE2]),
    .i_signed(sgn2),
    .i_value(val2),
    .i_limit(st_q.nv[1]),
    .i_samples(st_q.nv[3][SMP_W-1:0]),
    .o_alarm(alarm[1])
  );

  // Shared indicator: no channel identity, no latching
  always_comb begin
    any_alarm = |alarm;
    ind_level = st_q.ctrl[CTRL_OUT_POL] ? any_alarm : !any_alarm;
  end

  // Pin ownership by priority
  dsam_pin_mux u_pin_mux (
    .i_misc_claim(i_misc_claim),
    .i_misc_level(i_misc_level),
    .i_alarm_en(st_q.ctrl[CTRL_OUT_EN]),
    .i_alarm_line(st_q.ctrl[CTRL_OUT_LINE]),
    .i_alarm_level(ind_level),
    .i_gpio_oe(i_gpio_oe),
    .i_gpio_level(i_gpio_level),
    .o_out(mux_out),
    .o_oe(mux_oe)
  );

  // Serial edge and frame decode, all from second stage onward
  always_comb begin
    sclk_rise = st_q.sclk_s[1] && !st_q.sclk_s[2];
    sclk_fall = !st_q.sclk_s[1] && st_q.sclk_s[2];
    cs_act = !st_q.cs_s[1];
    cs_fall = !st_q.cs_s[1] && st_q.cs_s[2];
    rx_full = {st_q.rx[14:0], st_q.din_s[1]};
    frame_done = cs_act && sclk_rise && (st_q.bits == 5'(FRAME_BITS - 1));
    wr_addr = rx_full[FRAME_ADDR_LSB +: ADDR_W];
    wr_byte = rx_full[7:0];
  end

  // Next state of the whole block
  always_comb begin
    st_d = st_q;
    // Pins pass two flops before any logic reads them
    st_d.sclk_s = {st_q.sclk_s[1:0], i_spi_sclk};
    st_d.cs_s = {st_q.cs_s[1:0], i_spi_cs_n};
    st_d.din_s = {st_q.din_s[0], i_spi_din};
    // Line outputs are registered so the pins never glitch
    st_d.aux_out = mux_out;
    st_d.aux_oe = mux_oe;
    st_d.miso_oe = cs_act;
    if (!cs_act) begin
      // Deselect aborts any partial frame
      st_d.bits = '0;
    end else if (cs_fall) begin
      // Read data for the address named by the previous frame
      st_d.tx = reg_read(st_q.rd_addr, st_q, alarm);
      st_d.miso = st_d.tx[15];
      st_d.bits = '0;
    end else begin
      if (sclk_fall) begin
        // Shift out on the falling edge, host samples on rising; the
        // first fall re-presents the MSB so sixteen rises see 15 down to 0
        st_d.tx = {st_q.tx[14:0], 1'b0};
        st_d.miso = st_q.tx[15];
      end
      if (sclk_rise) begin
        st_d.rx = rx_full;
        st_d.bits = st_q.bits + 5'h01;
      end
      if (frame_done) begin
        st_d.bits = '0;
        if (rx_full[FRAME_WR_BIT]) begin
          // Byte write; odd address is the high byte
          if (wr_addr[ADDR_W-1:3] == ADDR_LIM1[ADDR_W-1:3]) begin
            if (wr_addr[0]) begin
              st_d.nv[wr_addr[2:1]][15:8] = wr_byte;
            end else begin
              st_d.nv[wr_addr[2:1]][7:0] = wr_byte;
            end
            st_d.nv[wr_addr[2:1]] = st_d.nv[wr_addr[2:1]] & wr_mask(wr_addr);
          end else if ({wr_addr[ADDR_W-1:1], 1'b0} == ADDR_CTRL) begin
            if (wr_addr[0]) begin
              st_d.ctrl[15:8] = wr_byte;
            end else begin
              st_d.ctrl[7:0] = wr_byte;
            end
            st_d.ctrl = st_d.ctrl & MASK_CTRL;
          end
        end else begin
          // Read request: data goes out in the next frame
          st_d.rd_addr = wr_addr;
        end
      end
    end
  end

  // State register. The user reset keeps the nonvolatile registers;
  // only power-on clears them, standing in for the stored copy
  always_ff @(posedge i_clk_sys) begin
    if (i_por) begin
      st_q <= '0;
      st_q.sclk_s <= 3'h7;
      st_q.cs_s <= 3'h7;
      st_q.nv <= {4{NV_RESET}};
      st_q.ctrl <= CTRL_RESET;
    end else if (i_rst) begin
      st_q.sclk_s <= 3'h7;
      st_q.cs_s <= 3'h7;
      st_q.din_s <= 2'h0;
      st_q.rx <= 16'h0000;
      st_q.tx <= 16'h0000;
      st_q.bits <= 5'h00;
      st_q.rd_addr <= 7'h00;
      st_q.nv <= st_q.nv;
      st_q.ctrl <= CTRL_RESET;
      st_q.aux_out <= 2'h0;
      st_q.aux_oe <= 2'h0;
      st_q.miso <= 1'b0;
      st_q.miso_oe <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_spi_dout = st_q.miso;
  assign o_spi_dout_oe = st_q.miso_oe;
  assign o_aux_out = st_q.aux_out;
  assign o_aux_oe = st_q.aux_oe;

  // Misc control owns both lines when it claims them
  misc_priority_a: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_por)
    i_misc_claim == 2'h3 |=> o_aux_oe == 2'h3 && o_aux_out == $past(i_misc_level))
    else $error("misc control lost a line");

  // Alarm drives line zero over general I/O and follows the alarm state
  alarm_line0_a: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_por)
    st_q.ctrl[CTRL_OUT_EN] && !st_q.ctrl[CTRL_OUT_LINE] && !i_misc_claim[0]
    |=> o_aux_oe[0] && o_aux_out[0] == ($past(st_q.ctrl[CTRL_OUT_POL]) ~^ $past(any_alarm)))
    else $error("indicator wrong on line zero");

  // Alarm on line one leaves line zero to general I/O
  alarm_line1_a: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_por)
    st_q.ctrl[CTRL_OUT_EN] && st_q.ctrl[CTRL_OUT_LINE] && i_misc_claim == 2'h0
    |=> o_aux_oe[1] && o_aux_oe[0] == $past(i_gpio_oe[0]))
    else $error("indicator on wrong line");

  // Disabled indicator never takes a line
  ind_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_por)
    !st_q.ctrl[CTRL_OUT_EN] && i_misc_claim == 2'h0 |=> o_aux_oe == $past(i_gpio_oe))
    else $error("disabled indicator drove a line");

  // Unused bits never hold ones
  unused_bits_a: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_por)
    !st_q.nv[0][14] && !st_q.nv[1][14] && st_q.nv[2][15:8] == 8'h00 && st_q.nv[3][15:8] == 8'h00
    && st_q.ctrl[7:3] == 5'h00)
    else $error("unused register bit set");

  // A low-byte write to limit two lands in the next cycle
  limit_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_por)
    frame_done && rx_full[FRAME_WR_BIT] && wr_addr == ADDR_LIM2
    |=> st_q.nv[1][7:0] == $past(wr_byte))
    else $error("limit write lost");

  // Source code 000 silences channel one in the next cycle
  src_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_por)
    src1 == SRC_OFF |=> !alarm[0])
    else $error("disabled channel one alarms");

  // Data out is released whenever the select is idle
  miso_release_a: assert property (@(posedge i_clk_sys) disable iff (i_rst || i_por)
    st_q.cs_s[1] |=> !o_spi_dout_oe)
    else $error("data out driven while deselected");

endmodule : dsam_top

// >>> testbench/dsam_host.sv
// Host model: serial mode 3 frames of 16 bits, MSB first.
// Assumes the device clock; each serial phase lasts 4 clocks.
`timescale 1ns/1ns
module dsam_host (
  input wire logic i_clk_sys, // System clock
  input wire logic i_spi_dout, // Device data out
  output logic o_sclk, // Serial clock, idle high
  output logic o_cs_n, // Select, low
  output logic o_din // Data to device
);
  // Idle: clock stands high outside frames
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  // Step to just after a clock edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys) #1;
  endtask : cyc
  // One frame; slow phases cover the device's two-flop synchroniser
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    o_cs_n = 1'b0;
    cyc(4);
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_din = tx[i];
      cyc(4);
      o_sclk = 1'b1;
      cyc(4);
      rx[i] = i_spi_dout;
    end
    cyc(1);
    o_cs_n = 1'b1;
    // Released line flips so a stale bit never looks valid
    o_din = ~o_din;
    cyc(5);
  endtask : xfer
endmodule : dsam_host

// >>> testbench/dsam_top_tb.sv
// Self-checking bench for the dual alarm monitor top.
// Assumes the host model owns the serial pins; the bench drives samples.
`timescale 1ns/1ns
module dsam_top_tb;
  import dsam_pkg::*;
  logic i_clk_sys, i_rst, i_por, sclk, cs_n, din, dout, dout_oe, valid; // Pins
  logic [SRC_NUM-1:0][LIM_W-1:0] raw; // Raw samples
  logic [1:0] mclaim, mlvl, goe, glvl, aout, aoe; // Aux line controls
  logic [15:0] rx; // Read data
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  dsam_top u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_por(i_por), .i_spi_sclk(sclk),
    .i_spi_cs_n(cs_n), .i_spi_din(din), .o_spi_dout(dout), .o_spi_dout_oe(dout_oe),
    .i_sample_valid(valid), .i_raw_sample(raw), .i_misc_claim(mclaim), .i_misc_level(mlvl),
    .i_gpio_oe(goe), .i_gpio_level(glvl), .o_aux_out(aout), .o_aux_oe(aoe));
  // Data out shows its inverse while not enabled, so a late enable breaks reads
  dsam_host u_host (.i_clk_sys(i_clk_sys), .i_spi_dout(dout_oe ? dout : ~dout), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_din(din));
  // 20 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // Hang guard: the sequence needs about 6700 cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys) #1;
  endtask : cyc
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // A 16-bit write is two byte frames, low byte at the even address
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_host.xfer({1'b1, a, d[7:0]}, rx);
    u_host.xfer({1'b1, a + 7'h01, d[15:8]}, rx);
  endtask : wr
  // Read data comes back in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    u_host.xfer({1'b0, a, 8'h00}, rx);
    u_host.xfer(16'h0000, d);
  endtask : rd
  // One sample update; lines are looked at two cycles after the pulse
  task automatic smp(input int idx, input logic [13:0] v, input logic [3:0] exp);
    raw[idx] = v;
    valid = 1'b1;
    cyc(1);
    valid = 1'b0;
    cyc(2);
    chk("aux oe,out", {12'h000, aoe, aout}, {12'h000, exp});
  endtask : smp
  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    i_rst = 1'b1;
    i_por = 1'b1;
    valid = 1'b0;
    raw = '0;
    mclaim = 2'b00;
    mlvl = 2'b00;
    goe = 2'b10;
    glvl = 2'b10;
    cyc(10);
    i_rst = 1'b0;
    i_por = 1'b0;
    cyc(4);
    // Defaults, then unused bits read back as zero
    for (int k = 0; k < 4; k++) begin
      rd(ADDR_LIM1 + 7'(2 * k), rx);
      chk("nv default", rx, 16'h0000);
      wr(ADDR_LIM1 + 7'(2 * k), 16'hFFFF);
      rd(ADDR_LIM1 + 7'(2 * k), rx);
      chk("nv mask", rx, (k < 2) ? MASK_LIM : MASK_SMP);
    end
    rd(7'h30, rx);
    chk("unmapped", rx, 16'h0000);
    // Plain reset keeps the nonvolatile limits
    i_rst = 1'b1;
    cyc(3);
    chk("reset outs", {11'h000, dout_oe, aoe, aout}, 16'h0000);
    i_rst = 1'b0;
    cyc(4);
    rd(ADDR_LIM1, rx);
    chk("limit kept", rx, MASK_LIM);
    $display("Test registers done");
    // Channel one threshold on X accel, line zero, active high
    wr(ADDR_LIM1, 16'h8064);
    wr(ADDR_CTRL, 16'h0206);
    smp(1, 14'd101, 4'b1111);
    rd(ADDR_STATUS, rx);
    chk("status", rx, 16'h0001);
    smp(1, 14'd100, 4'b1110);
    wr(ADDR_LIM1, 16'h3FFB);
    smp(1, 14'h3FFA, 4'b1111);
    smp(1, 14'h0001, 4'b1110);
    $display("Test threshold done");
    // Channel two on temperature, own limit, line one, active low
    wr(ADDR_LIM2, 16'h8010);
    wr(ADDR_CTRL, 16'h5005);
    smp(4, 14'd16, 4'b1010);
    smp(4, 14'd17, 4'b1000);
    mclaim = 2'b11;
    mlvl = 2'b10;
    cyc(2);
    chk("misc wins", {12'h000, aoe, aout}, 16'h000E);
    mclaim = 2'b00;
    wr(ADDR_CTRL, 16'h0005);
    cyc(2);
    chk("src off", {12'h000, aoe, aout}, 16'h000A);
    $display("Test channel two done");
    // Channel one rate mode, two samples per window, 10 per sample
    goe = 2'b00;
    glvl = 2'b00;
    wr(ADDR_SMP1, 16'h0002);
    wr(ADDR_LIM1, 16'h800A);
    wr(ADDR_CTRL, 16'h0A06);
    smp(1, 14'd0, 4'b0100);
    smp(1, 14'd5, 4'b0100);
    smp(1, 14'd30, 4'b0101);
    smp(1, 14'd35, 4'b0101);
    smp(1, 14'd45, 4'b0100);
    $display("Test rate done");
    end_of_test();
  end
endmodule : dsam_top_tb
